// *** hdl/swc_holdoff.sv ***
/*
 holdoff timer: counts a loaded number of cycles after a start pulse.
 assumes start is a pulse from a flip-flop in the sequencer: one cycle long, except that it stays high for as long as an abort command lasts.
*/
`timescale 1ns/1ns
module swc_holdoff
#(
   parameter int WIDTH = swc_pkg::HOLD_WIDTH
)
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic start,
   input wire logic [WIDTH-1:0] length,
   output logic done
);
   typedef struct packed
   {
      logic [WIDTH-1:0] count;
      logic done;
   } swc_hold_state_type;

   swc_hold_state_type r;
   swc_hold_state_type next_r;

   // masking with start hides a stale done from the previous interval
   assign done = r.done & ~start;

   always_comb
   begin
      next_r = r;
      if (start)
      begin
         next_r.count = length;
         next_r.done = 1'b0;
      end
      else if (!r.done)
      begin
         if (r.count <= WIDTH'(1))
            next_r.done = 1'b1;
         next_r.count = r.count - WIDTH'(1);
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         r.count <= '0;
         r.done <= 1'b1;
      end
      else
         r <= next_r;
   end

   a_hold_restart: assert property (@(posedge clock) disable iff (!rst_n)
      start && length > WIDTH'(2) |=> !done ##1 !done)
      else $error("holdoff finished too early after start");
endmodule

// *** hdl/swc_pkg.sv ***
/*
 sweep control sequencer package: port addresses, field positions,
 holdoff timing and sequencer states.
 assumes a 100 MHz system clock.
*/
package swc_pkg;
   localparam int CLOCK_NS = 10;
   localparam logic [7:0] RATE_PORT_ADDR = 8'h0F;
   localparam logic [7:0] HOLD_PORT_ADDR = 8'h1F;
   localparam logic [7:0] RATE_PORT_RESET = 8'h00;
   localparam logic [7:0] HOLD_PORT_RESET = 8'h00;
   localparam int ADDR_POLL_BIT = 7;
   // sweep rate port fields
   localparam int SINGLE_CMD_BIT = 0;
   localparam int SINGLE_MODE_BIT = 2;
   localparam int DECADE_LSB = 3;
   localparam int STEP_LSB = 5;
   localparam int RATE_CODE_LSB = 3;
   localparam logic [4:0] RATE_MANUAL = 5'h1F;
   localparam logic [4:0] RATE_EXTERNAL = 5'h0F;
   localparam logic [1:0] DECADE_FAST = 2'h3;
   localparam logic [1:0] DECADE_MID = 2'h1;
   localparam logic [1:0] DECADE_SLOW = 2'h0;
   // holdoff port fields
   localparam int ABORT_CMD_BIT = 0;
   localparam int EXTEND_A_BIT = 4;
   localparam int EXTEND_B_BIT = 5;
   localparam int END_IRQ_EN_BIT = 6;
   // holdoff timing: least times, rounded up to whole cycles
   localparam int HOLD_WIDTH = 13;
   localparam int HOLD_BASE_NS = 10000;
   localparam int HOLD_DECADE_NS = 10000;
   localparam int HOLD_EXT_A_NS = 5000;
   localparam int HOLD_EXT_B_NS = 10000;
   localparam logic [HOLD_WIDTH-1:0] HOLD_BASE_CYC = HOLD_WIDTH'((HOLD_BASE_NS + CLOCK_NS - 1) / CLOCK_NS);
   localparam logic [HOLD_WIDTH-1:0] HOLD_DECADE_CYC = HOLD_WIDTH'((HOLD_DECADE_NS + CLOCK_NS - 1) / CLOCK_NS);
   localparam logic [HOLD_WIDTH-1:0] HOLD_EXT_A_CYC = HOLD_WIDTH'((HOLD_EXT_A_NS + CLOCK_NS - 1) / CLOCK_NS);
   localparam logic [HOLD_WIDTH-1:0] HOLD_EXT_B_CYC = HOLD_WIDTH'((HOLD_EXT_B_NS + CLOCK_NS - 1) / CLOCK_NS);
   typedef enum logic [2:0]
   {
      SWC_SWEEP = 3'b001,
      SWC_HOLDOFF = 3'b010,
      SWC_ARMED = 3'b100
   } swc_phase_type;
endpackage

// *** hdl/swc_sequencer.sv ***
/*
 sweep control sequencer: host port decode and latching, pulsed commands,
 sweep end / holdoff / trigger enable / restart cycle, single sweep, abort,
 end-of-sweep service request with serial poll and clear.
 assumes all inputs synchronous to clock; ramp_at_end is a level from the
 end-of-sweep comparator; the open-collector lines are resolved outside.
*/
// Contract
// - sweep end: set cycle, blank, discharge
// - holdoff begins immediately at sweep end
// - slower sweep rates get longer holdoff
// - two extension bits lengthen holdoff
// - holdoff done, not single: enable trigger
// - trigger path low when disabled, else fires
// - trigger path rise restarts the sweep
// - single sweep: one sweep per host command
// - abort pulse ends sweep, awaits trigger
// - decode two ports, active-low strobes
// - latch data at strobe rising edge
// - pulsed bits: strobe gated with data
// - bits seven to three select rate
// - bits four, three choose decade
// - bits seven to five choose step
// - codes for manual and external drive
// - bit two single mode, bit zero command
// - bit six enables end interrupt
// - pending request pulls service line low
// - poll with bit seven reads, pull data four
// - poll without bit seven clears request
`timescale 1ns/1ns
module swc_sequencer
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [7:0] addr,
   input wire logic [7:0] data_in,
   input wire logic data_valid,
   input wire logic poll,
   input wire logic ramp_at_end,
   input wire logic trigger_in,
   input wire logic free_run,
   input wire logic service_request_n_in,
   output logic rate_port_strobe_n,
   output logic hold_port_strobe_n,
   output logic single_cmd_pulse_n,
   output logic abort_cmd_pulse_n,
   output logic [1:0] decade_range,
   output logic [2:0] rate_step,
   output logic manual_scan,
   output logic external_drive,
   output logic single_sweep_mode,
   output logic holdoff_extend_a,
   output logic holdoff_extend_b,
   output logic end_interrupt_enable,
   output logic sweep_cycle,
   output logic sweep_gate_active,
   output logic ramp_discharge,
   output logic trigger_enable,
   output logic trigger_path_out,
   output logic service_request_n_out,
   output logic service_request_n_oe_n,
   output logic data_bit_four_out,
   output logic data_bit_four_oe_n
);
   typedef struct packed
   {
      swc_pkg::swc_phase_type phase;
      logic [7:0] rate_reg;
      logic [7:0] hold_reg;
      logic [7:0] sample;
      logic rate_sel_d;
      logic hold_sel_d;
      logic rate_strobe_n;
      logic hold_strobe_n;
      logic single_pulse_n;
      logic abort_pulse_n;
      logic single_fired;
      logic trig_prev;
      logic manual;
      logic external;
      logic trig_out;
      logic trig_en;
      logic hold_start;
      logic pending;
      logic gate;
      logic discharge;
      logic read_drive;
   } swc_state_type;

   swc_state_type r;
   swc_state_type next_r;
   logic addr_bit_seven;
   logic rate_sel;
   logic hold_sel;
   logic single_cmd;
   logic abort_cmd;
   logic special_mode;
   logic sweep_end;
   logic irq_set;
   logic irq_clear;
   logic poll_read;
   logic hold_done;
   logic [swc_pkg::HOLD_WIDTH-1:0] hold_length;
   logic [4:0] rate_code;

   assign addr_bit_seven = addr[swc_pkg::ADDR_POLL_BIT];
   assign rate_sel = data_valid && addr == swc_pkg::RATE_PORT_ADDR;
   assign hold_sel = data_valid && addr == swc_pkg::HOLD_PORT_ADDR;
   // command pulses last exactly as long as data valid
   assign single_cmd = rate_sel && data_in[swc_pkg::SINGLE_CMD_BIT];
   assign abort_cmd = hold_sel && data_in[swc_pkg::ABORT_CMD_BIT];
   assign rate_code = r.rate_reg[7:swc_pkg::RATE_CODE_LSB];
   assign special_mode = rate_code == swc_pkg::RATE_MANUAL || rate_code == swc_pkg::RATE_EXTERNAL;
   assign sweep_end = r.phase == swc_pkg::SWC_SWEEP && ramp_at_end && !special_mode;
   assign irq_set = sweep_end && r.hold_reg[swc_pkg::END_IRQ_EN_BIT];
   assign poll_read = poll && addr_bit_seven;
   assign irq_clear = poll && !addr_bit_seven;

   // slower decades and each extension bit add their own share
   always_comb
   begin
      hold_length = swc_pkg::HOLD_BASE_CYC;
      case (r.rate_reg[swc_pkg::DECADE_LSB +: 2])
         swc_pkg::DECADE_FAST: hold_length = hold_length;
         swc_pkg::DECADE_MID: hold_length = hold_length + swc_pkg::HOLD_DECADE_CYC;
         swc_pkg::DECADE_SLOW: hold_length = hold_length + (swc_pkg::HOLD_DECADE_CYC << 1);
         default: hold_length = hold_length;
      endcase
      if (r.hold_reg[swc_pkg::EXTEND_A_BIT])
         hold_length = hold_length + swc_pkg::HOLD_EXT_A_CYC;
      if (r.hold_reg[swc_pkg::EXTEND_B_BIT])
         hold_length = hold_length + swc_pkg::HOLD_EXT_B_CYC;
   end

   swc_holdoff #(.WIDTH(swc_pkg::HOLD_WIDTH)) u_holdoff
   (
      .clock(clock),
      .rst_n(rst_n),
      .start(r.hold_start),
      .length(hold_length),
      .done(hold_done)
   );

   always_comb
   begin
      next_r = r;
      next_r.hold_start = 1'b0;
      next_r.trig_out = 1'b0;
      // port strobes and pulsed bits follow the bus one cycle later, through flip-flops
      next_r.rate_sel_d = rate_sel;
      next_r.hold_sel_d = hold_sel;
      next_r.rate_strobe_n = !rate_sel;
      next_r.hold_strobe_n = !hold_sel;
      next_r.single_pulse_n = !single_cmd;
      next_r.abort_pulse_n = !abort_cmd;
      if (data_valid)
         next_r.sample = data_in;
      // data is latched when the strobe rises, i.e. data valid ends
      if (r.rate_sel_d && !rate_sel)
         next_r.rate_reg = r.sample;
      if (r.hold_sel_d && !hold_sel)
         next_r.hold_reg = r.sample;
      // cleared once, as the command pulse ends: clearing on every cycle of a
      // long pulse would re-arm a sweep that has already started
      if (!single_cmd && !r.single_pulse_n)
         next_r.single_fired = 1'b0;
      next_r.trig_prev = trigger_in;

      case (r.phase)
         swc_pkg::SWC_SWEEP:
         begin
            if (sweep_end || abort_cmd)
            begin
               next_r.phase = swc_pkg::SWC_HOLDOFF;
               next_r.hold_start = 1'b1;
            end
         end
         swc_pkg::SWC_HOLDOFF:
         begin
            if (abort_cmd)
               next_r.hold_start = 1'b1;
            else if (hold_done && !r.hold_start)
               next_r.phase = swc_pkg::SWC_ARMED;
         end
         swc_pkg::SWC_ARMED:
         begin
            if (abort_cmd)
            begin
               next_r.phase = swc_pkg::SWC_HOLDOFF;
               next_r.hold_start = 1'b1;
            end
            else if (r.trig_en && (free_run || (trigger_in && !r.trig_prev)))
            begin
               next_r.trig_out = 1'b1;
               next_r.phase = swc_pkg::SWC_SWEEP;
               next_r.single_fired = 1'b1;
            end
         end
         default:
         begin
            next_r.phase = swc_pkg::SWC_HOLDOFF;
            next_r.hold_start = 1'b1;
         end
      endcase

      // manual and external drive keep the cycle flip-flop reset
      if (special_mode)
      begin
         next_r.phase = swc_pkg::SWC_SWEEP;
         next_r.hold_start = 1'b0;
      end

      // enable only once armed; single mode also needs a host command
      next_r.trig_en = next_r.phase == swc_pkg::SWC_ARMED
         && (!r.rate_reg[swc_pkg::SINGLE_MODE_BIT] || !next_r.single_fired);
      next_r.gate = next_r.phase == swc_pkg::SWC_SWEEP;
      next_r.discharge = next_r.phase != swc_pkg::SWC_SWEEP;
      next_r.manual = next_r.rate_reg[7:swc_pkg::RATE_CODE_LSB] == swc_pkg::RATE_MANUAL;
      next_r.external = next_r.rate_reg[7:swc_pkg::RATE_CODE_LSB] == swc_pkg::RATE_EXTERNAL;

      // a new sweep end beats a clear arriving in the same cycle
      if (irq_set)
         next_r.pending = 1'b1;
      else if (irq_clear)
         next_r.pending = 1'b0;
      next_r.read_drive = poll_read && r.pending;
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         r.phase <= swc_pkg::SWC_HOLDOFF;
         r.rate_reg <= swc_pkg::RATE_PORT_RESET;
         r.hold_reg <= swc_pkg::HOLD_PORT_RESET;
         r.sample <= 8'h00;
         r.rate_sel_d <= 1'b0;
         r.hold_sel_d <= 1'b0;
         r.rate_strobe_n <= 1'b1;
         r.hold_strobe_n <= 1'b1;
         r.single_pulse_n <= 1'b1;
         r.abort_pulse_n <= 1'b1;
         r.single_fired <= 1'b1;
         r.trig_prev <= 1'b0;
         r.manual <= 1'b0;
         r.external <= 1'b0;
         r.trig_out <= 1'b0;
         r.trig_en <= 1'b0;
         r.hold_start <= 1'b1;
         r.pending <= 1'b0;
         r.gate <= 1'b0;
         r.discharge <= 1'b1;
         r.read_drive <= 1'b0;
      end
      else
         r <= next_r;
   end

   assign rate_port_strobe_n = r.rate_strobe_n;
   assign hold_port_strobe_n = r.hold_strobe_n;
   assign single_cmd_pulse_n = r.single_pulse_n;
   assign abort_cmd_pulse_n = r.abort_pulse_n;
   assign decade_range = r.rate_reg[swc_pkg::DECADE_LSB +: 2];
   assign rate_step = r.rate_reg[swc_pkg::STEP_LSB +: 3];
   assign manual_scan = r.manual;
   assign external_drive = r.external;
   assign single_sweep_mode = r.rate_reg[swc_pkg::SINGLE_MODE_BIT];
   assign holdoff_extend_a = r.hold_reg[swc_pkg::EXTEND_A_BIT];
   assign holdoff_extend_b = r.hold_reg[swc_pkg::EXTEND_B_BIT];
   assign end_interrupt_enable = r.hold_reg[swc_pkg::END_IRQ_EN_BIT];
   assign sweep_cycle = r.discharge;
   assign sweep_gate_active = r.gate;
   assign ramp_discharge = r.discharge;
   assign trigger_enable = r.trig_en;
   assign trigger_path_out = r.trig_out;
   // open-collector lines only ever pull low
   assign service_request_n_out = 1'b0;
   assign service_request_n_oe_n = !r.pending;
   assign data_bit_four_out = 1'b0;
   assign data_bit_four_oe_n = !r.read_drive;

   a_end_blanks: assert property (@(posedge clock) disable iff (!rst_n)
      sweep_end |=> !sweep_gate_active && ramp_discharge)
      else $error("sweep end did not blank and discharge");

   a_holdoff_start: assert property (@(posedge clock) disable iff (!rst_n)
      sweep_end && !special_mode |=> r.hold_start && r.phase == swc_pkg::SWC_HOLDOFF)
      else $error("holdoff did not start at sweep end");

   a_trig_low_hold: assert property (@(posedge clock) disable iff (!rst_n)
      r.phase == swc_pkg::SWC_HOLDOFF |-> !trigger_path_out && !trigger_enable)
      else $error("trigger path active during holdoff");

   a_free_run_fire: assert property (@(posedge clock) disable iff (!rst_n)
      trigger_enable && free_run && !abort_cmd && !special_mode |=> trigger_path_out)
      else $error("free run did not fire at once");

   a_restart_sweep: assert property (@(posedge clock) disable iff (!rst_n)
      trigger_path_out |-> sweep_gate_active && !ramp_discharge)
      else $error("trigger rise did not restart sweep");

   a_single_once: assert property (@(posedge clock) disable iff (!rst_n)
      trigger_path_out && single_sweep_mode && !single_cmd |=> !trigger_enable [*2])
      else $error("single sweep re-armed without host command");

   a_abort_ends: assert property (@(posedge clock) disable iff (!rst_n)
      abort_cmd && !special_mode |=> !sweep_gate_active ##1 !trigger_enable)
      else $error("abort did not end the sweep");

   a_srq_pending: assert property (@(posedge clock) disable iff (!rst_n)
      irq_set |=> !service_request_n_oe_n)
      else $error("sweep end request not raised");

   a_poll_read: assert property (@(posedge clock) disable iff (!rst_n)
      poll_read && r.pending |=> !data_bit_four_oe_n)
      else $error("poll read did not pull data four");

   a_clear_req: assert property (@(posedge clock) disable iff (!rst_n)
      irq_clear && !irq_set |=> service_request_n_oe_n)
      else $error("clear did not release service request");

   a_port_latch: assert property (@(posedge clock) disable iff (!rst_n)
      rate_sel ##1 !rate_sel |=> r.rate_reg == $past(r.sample))
      else $error("rate port not latched at strobe rise");
endmodule

// *** tb/swc_host_model.sv ***
/*
 host model: writes the two ports and runs the serial poll read and clear.
 assumes one bench process calls its tasks, timed by clock.
*/
`timescale 1ns/1ns
module swc_host_model
(
   input wire logic clock,
   output logic [7:0] addr,
   output logic [7:0] data,
   output logic data_valid,
   output logic poll
);
   initial
   begin
      addr = 8'h00;
      data = 8'h00;
      data_valid = 1'b0;
      poll = 1'b0;
   end
   // data stays put until the edge after data_valid ends
   // an abort is a write with bit zero set to the holdoff port
   task automatic write_port(input logic [7:0] port, input logic [7:0] value, input int hold);
      @(posedge clock);
      addr <= port;
      data <= value;
      data_valid <= 1'b1;
      repeat (hold) @(posedge clock);
      data_valid <= 1'b0;
      @(posedge clock);
      // released bus shows the inverted byte and port, not the old ones
      data <= ~value;
      addr <= ~port;
   endtask
   // poll high with address bit seven high reads, low clears
   task automatic poll_start(input logic read);
      @(posedge clock);
      addr <= {read, 7'h00};
      poll <= 1'b1;
   endtask
   task automatic poll_end();
      @(posedge clock);
      poll <= 1'b0;
   endtask
endmodule

// *** tb/swc_sequencer_test.sv ***
/*
 self-checking bench for the sweep control sequencer.
 assumes the host model on the bus; comparator, trigger and pull-ups are driven here.
*/
`timescale 1ns/1ns
module swc_sequencer_test;
   logic clock = 1'b0;
   logic rst_n, data_valid, poll, ramp_at_end, trigger_in, free_run;
   logic [7:0] addr, data_in;
   logic rs_n, hs_n, sc_n, ab_n, man, ext, sgl, exa, exb, irq_en, cyc, gate, dis, ten, tpo;
   logic sr_out, sr_oe_n, d4_out, d4_oe_n;
   logic [1:0] dec;
   logic [2:0] stp;
   logic [7:0] rate_tab [5] = '{8'hD8, 8'hD8, 8'hD8, 8'hC8, 8'hC0};
   logic [7:0] hold_tab [5] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h00};
   int len_tab [5] = '{1000, 1500, 2000, 3500, 3000};
   logic [2:0] step_tab [6] = '{3'h6, 3'h5, 3'h4, 3'h2, 3'h1, 3'h0};
   int err_count = 0;
   int tests_run = 0;
   int cycles = 0;
   int n;
   // open-collector lines idle high through pull-ups
   wire srq_n = sr_oe_n ? 1'b1 : sr_out;
   wire d4_line = d4_oe_n ? 1'b1 : d4_out;
   always #5 clock = ~clock;
   swc_host_model HOST
   (
      .clock(clock), .addr(addr), .data(data_in), .data_valid(data_valid), .poll(poll)
   );
   swc_sequencer DUT
   (
      .clock(clock), .rst_n(rst_n), .addr(addr), .data_in(data_in), .data_valid(data_valid), .poll(poll),
      .ramp_at_end(ramp_at_end), .trigger_in(trigger_in), .free_run(free_run), .service_request_n_in(srq_n),
      .rate_port_strobe_n(rs_n), .hold_port_strobe_n(hs_n), .single_cmd_pulse_n(sc_n), .abort_cmd_pulse_n(ab_n),
      .decade_range(dec), .rate_step(stp), .manual_scan(man), .external_drive(ext), .single_sweep_mode(sgl),
      .holdoff_extend_a(exa), .holdoff_extend_b(exb), .end_interrupt_enable(irq_en), .sweep_cycle(cyc),
      .sweep_gate_active(gate), .ramp_discharge(dis), .trigger_enable(ten), .trigger_path_out(tpo),
      .service_request_n_out(sr_out), .service_request_n_oe_n(sr_oe_n), .data_bit_four_out(d4_out),
      .data_bit_four_oe_n(d4_oe_n)
   );
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp)
      begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_n(input string what, input int lo, input int hi, input int got);
      tests_run++;
      if (got < lo || got > hi)
      begin
         err_count++;
         $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, got);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge clock);
      #1;
   endtask
   task automatic wr(input logic [7:0] port, input logic [7:0] value);
      fork
         HOST.write_port(port, value, 4);
         begin
            tick(2);
            chk("rate strobe", 8'(port != swc_pkg::RATE_PORT_ADDR), rs_n);
            chk("hold strobe", 8'(port != swc_pkg::HOLD_PORT_ADDR), hs_n);
            chk("single pulse", 8'(!(port == swc_pkg::RATE_PORT_ADDR && value[0])), sc_n);
            chk("abort pulse", 8'(!(port == swc_pkg::HOLD_PORT_ADDR && value[0])), ab_n);
         end
      join
      tick(2);
   endtask
   task automatic sweep_end();
      @(posedge clock);
      ramp_at_end <= 1'b1;
      @(posedge clock);
      ramp_at_end <= 1'b0;
      #1;
      chk("gate", 8'h00, gate);
      chk("discharge", 8'h01, dis);
      chk("cycle", 8'h01, cyc);
   endtask
   // sel high waits for the gate, low for the trigger enable
   task automatic wait_on(input logic sel, input int limit);
      n = 0;
      while (((sel ? gate : ten) !== 1'b1) && n < limit)
      begin
         tick(1);
         n++;
      end
   endtask
   task automatic fire();
      tick(3);
      chk("path idle", 8'h00, tpo);
      chk("gate idle", 8'h00, gate);
      @(posedge clock);
      trigger_in <= 1'b1;
      wait_on(1'b1, 6);
      chk_n("restart", 0, 5, n);
      chk("enable drop", 8'h00, ten);
      @(posedge clock);
      trigger_in <= 1'b0;
   endtask
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // about 20000 cycles expected, so this only trips on a hang
   always @(posedge clock)
   begin
      cycles++;
      if (cycles == 60000)
      begin
         err_count++;
         end_sim();
      end
   end
   initial
   begin
      rst_n = 1'b0;
      ramp_at_end = 1'b0;
      trigger_in = 1'b0;
      free_run = 1'b0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      #1;
      chk("rate strobe", 8'h01, rs_n);
      chk("gate", 8'h00, gate);
      chk("enable", 8'h00, ten);
      chk("request", 8'h01, srq_n);
      // reset ports select the slowest decade: base plus two decade shares
      wait_on(1'b0, 3100);
      chk_n("reset holdoff", 3000, 3006, n);
      fire();
      for (int i = 0; i < 5; i++)
      begin
         wr(swc_pkg::RATE_PORT_ADDR, rate_tab[i]);
         wr(swc_pkg::HOLD_PORT_ADDR, hold_tab[i]);
         chk("decade", 8'(rate_tab[i][4:3]), 8'(dec));
         chk("step", 8'(rate_tab[i][7:5]), 8'(stp));
         chk("extend a", 8'(hold_tab[i][4]), exa);
         chk("extend b", 8'(hold_tab[i][5]), exb);
         sweep_end();
         chk("no request", 8'h01, srq_n);
         wait_on(1'b0, 4000);
         chk_n("holdoff", len_tab[i], len_tab[i] + 6, n);
         fire();
      end
      foreach (step_tab[i])
      begin
         wr(swc_pkg::RATE_PORT_ADDR, {step_tab[i], 5'h18});
         chk("step", 8'(step_tab[i]), 8'(stp));
      end
      for (int i = 0; i < 2; i++)
      begin
         wr(swc_pkg::RATE_PORT_ADDR, i[0] ? 8'h78 : 8'hF8);
         chk("manual", 8'(!i[0]), man);
         chk("external", 8'(i[0]), ext);
         @(posedge clock);
         ramp_at_end <= 1'b1;
         tick(3);
         chk("held sweep", 8'h01, gate);
         @(posedge clock);
         ramp_at_end <= 1'b0;
      end
      wr(swc_pkg::RATE_PORT_ADDR, 8'h18);
      wr(swc_pkg::HOLD_PORT_ADDR, 8'h40);
      chk("irq enable", 8'h01, irq_en);
      @(posedge clock);
      free_run <= 1'b1;
      sweep_end();
      tick(1);
      chk("request", 8'h00, srq_n);
      wait_on(1'b1, 1100);
      chk_n("free run", 990, 1010, n);
      HOST.poll_start(1'b1);
      tick(2);
      chk("poll answer", 8'h00, d4_line);
      HOST.poll_end();
      HOST.poll_start(1'b0);
      tick(2);
      chk("cleared", 8'h01, srq_n);
      HOST.poll_end();
      HOST.poll_start(1'b1);
      tick(2);
      chk("no answer", 8'h01, d4_line);
      HOST.poll_end();
      wr(swc_pkg::RATE_PORT_ADDR, 8'h1C);
      chk("single mode", 8'h01, sgl);
      sweep_end();
      wait_on(1'b0, 1200);
      chk_n("single held", 1200, 1200, n);
      wr(swc_pkg::RATE_PORT_ADDR, 8'h1D);
      wait_on(1'b1, 20);
      chk_n("single start", 0, 19, n);
      sweep_end();
      wait_on(1'b0, 1200);
      chk_n("one sweep", 1200, 1200, n);
      wr(swc_pkg::RATE_PORT_ADDR, 8'h18);
      wait_on(1'b1, 20);
      chk("running", 8'h01, gate);
      wr(swc_pkg::HOLD_PORT_ADDR, 8'h01);
      chk("abort blank", 8'h00, gate);
      chk("abort discharge", 8'h01, dis);
      wait_on(1'b1, 1100);
      chk_n("abort restart", 990, 1010, n);
      end_sim();
   end
endmodule
